// ### core/control_word_decoder.sv
// Control word command decoder with edge detection of enable and fault reset
`timescale 1ns/1ps
`default_nettype none
module control_word_decoder
   import drive_power_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] control_word,
   input  wire logic [7:0]  mode_of_operation,
   output drive_cmd_t       cmd,
   output mode_bits_t       mode_bits
);

   logic enable_op_prev_reg;
   logic fault_reset_prev_reg;

   // ****************************************
   // Edge history
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         enable_op_prev_reg   <= 1'b0;
         fault_reset_prev_reg <= 1'b0;
      end else begin
         enable_op_prev_reg   <= control_word[CW_ENABLE_OP];
         fault_reset_prev_reg <= control_word[CW_FAULT_RESET];
      end
   end

   // ****************************************
   // Command decode; bits 9 to 15 never looked at
   // ****************************************
   always_comb begin
      logic so;
      logic dv;
      logic qs;
      logic eo;
      so = control_word[CW_SWITCH_ON];
      dv = control_word[CW_DISABLE_V];
      qs = control_word[CW_QUICK_STOP];
      eo = control_word[CW_ENABLE_OP];
      cmd.cmd_shutdown        = qs & dv & ~so;
      cmd.cmd_switch_on       = qs & dv & so;
      cmd.cmd_disable_voltage = ~dv;
      cmd.cmd_quick_stop      = ~qs & dv;
      cmd.cmd_disable_op      = ~eo & qs & dv & so;
      cmd.cmd_enable_op       = eo & qs & dv & so;
      cmd.cmd_fault_reset     = control_word[CW_FAULT_RESET] & ~fault_reset_prev_reg;
      cmd.enable_op_rise      = eo & ~enable_op_prev_reg;
      cmd.pause               = control_word[CW_PAUSE];
   end

   // Mode-specific bits; unused modes leave them reserved
   always_comb begin
      mode_bits = '0;
      unique case (mode_of_operation)
         MODE_PROFILE_POSITION: begin
            mode_bits.new_setpoint       = control_word[CW_MODE_LO];
            mode_bits.change_immediately = control_word[CW_MODE_MID];
            mode_bits.absolute_relative  = control_word[CW_MODE_HI];
         end
         MODE_REFERENCE_SEARCH: begin
            mode_bits.reference_search_start = control_word[CW_MODE_LO];
         end
         default: begin
            mode_bits = '0;
         end
      endcase
   end

endmodule : control_word_decoder
`default_nettype wire

// ### core/drive_power_pkg.sv
// Package: drive power state machine constants, types and word layouts
`default_nettype none
package drive_power_pkg;

   // ****************************************
   // Control word bit positions
   // ****************************************
   localparam int CW_SWITCH_ON   = 0;
   localparam int CW_DISABLE_V   = 1;
   localparam int CW_QUICK_STOP  = 2;
   localparam int CW_ENABLE_OP   = 3;
   localparam int CW_MODE_LO     = 4;
   localparam int CW_MODE_MID    = 5;
   localparam int CW_MODE_HI     = 6;
   localparam int CW_FAULT_RESET = 7;
   localparam int CW_PAUSE       = 8;

   // ****************************************
   // Status word bit positions
   // ****************************************
   localparam int SW_READY       = 0;
   localparam int SW_SWITCHED_ON = 1;
   localparam int SW_OP_ENABLED  = 2;
   localparam int SW_FAULT       = 3;
   localparam int SW_VOLTAGE     = 4;
   localparam int SW_QUICK_STOP  = 5;
   localparam int SW_SO_DISABLED = 6;
   localparam int SW_WARNING     = 7;
   localparam int SW_REMOTE      = 9;
   localparam int SW_TARGET      = 10;
   localparam int SW_LIMIT       = 11;

   localparam logic [15:0] WORD_ZERO = 16'h0000;

   // ****************************************
   // Mode of operation codes
   // ****************************************
   localparam logic [7:0] MODE_PROFILE_POSITION = 8'h01;
   localparam logic [7:0] MODE_PROFILE_VELOCITY = 8'h03;
   localparam logic [7:0] MODE_PROFILE_TORQUE   = 8'h04;
   localparam logic [7:0] MODE_REFERENCE_SEARCH = 8'h06;
   localparam logic [7:0] MODE_INTERPOLATED     = 8'h07;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      ST_NOT_READY      = 3'b000,
      ST_SO_DISABLED    = 3'b001,
      ST_READY          = 3'b011,
      ST_SWITCHED_ON    = 3'b010,
      ST_OP_ENABLED     = 3'b110,
      ST_QUICK_STOP     = 3'b111,
      ST_FAULT_REACTION = 3'b101,
      ST_FAULT          = 3'b100
   } drive_state_t;

   typedef struct packed {
      logic cmd_shutdown;
      logic cmd_switch_on;
      logic cmd_disable_voltage;
      logic cmd_quick_stop;
      logic cmd_disable_op;
      logic cmd_enable_op;
      logic cmd_fault_reset;
      logic enable_op_rise;
      logic pause;
   } drive_cmd_t;

   typedef struct packed {
      logic new_setpoint;
      logic change_immediately;
      logic absolute_relative;
      logic reference_search_start;
   } mode_bits_t;

   typedef struct packed {
      logic booting;
      logic fault_present;
      logic voltage_present;
      logic warning_any;
      logic target_reached;
      logic limit_active;
      logic ramp_done;
   } drive_cond_t;

endpackage : drive_power_pkg
`default_nettype wire

// ### core/drive_power_state_machine.sv
// Drive power-stage state machine: control word in, status word out
`timescale 1ns/1ps
`default_nettype none
module drive_power_state_machine
   import drive_power_pkg::*;
#(
   parameter int WARN_W = 8
)
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic [15:0]       control_word,
   input  wire logic              cycle_strobe,
   input  wire logic [7:0]        mode_of_operation,
   input  wire logic              booting,
   input  wire logic              fault_present,
   input  wire logic              voltage_present,
   input  wire logic [WARN_W-1:0] warning_causes,
   input  wire logic              target_reached,
   input  wire logic              limit_active,
   input  wire logic              ramp_done,
   input  wire logic [31:0]       setpoint_in,
   output logic [15:0]            status_word,
   output logic [WARN_W-1:0]      warning_detail,
   output logic [31:0]            setpoint_out,
   output logic                   setpoint_valid,
   output logic                   power_stage_enable,
   output logic                   quick_stop_ramp,
   output logic                   emergency_ramp,
   output logic                   halt_motion,
   output mode_bits_t             mode_bits,
   output drive_state_t           state
);

   if (WARN_W < 1 || WARN_W > 16) begin : g_bad_warn
      $error("WARN_W out of range");
   end

   drive_cmd_t   cmd;
   drive_cond_t  cond;
   drive_state_t state_reg;
   drive_state_t state_next;
   logic [31:0]  setpoint_reg;
   logic         setpoint_valid_reg;
   logic [WARN_W-1:0] warning_reg;

   // ****************************************
   // Sub-blocks
   // ****************************************
   control_word_decoder u_decoder (
      .clk               (clk),
      .sys_rst           (sys_rst),
      .control_word      (control_word),
      .mode_of_operation (mode_of_operation),
      .cmd               (cmd),
      .mode_bits         (mode_bits)
   );

   always_comb begin
      cond.booting         = booting;
      cond.fault_present   = fault_present;
      cond.voltage_present = voltage_present;
      cond.warning_any     = |warning_causes;
      cond.target_reached  = target_reached;
      cond.limit_active    = limit_active;
      cond.ramp_done       = ramp_done;
   end

   status_word_encoder u_encoder (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .state       (state_reg),
      .cond        (cond),
      .status_word (status_word)
   );

   // ****************************************
   // Transition logic
   // ****************************************
   // Fault detection takes priority over every command so a fault
   // is never masked by a control word arriving in the same cycle.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_NOT_READY: begin
            if (!booting && !fault_present) begin
               state_next = ST_SO_DISABLED;
            end
         end
         ST_SO_DISABLED: begin
            if (fault_present) begin
               state_next = ST_FAULT_REACTION;
            end else if (cmd.cmd_shutdown && voltage_present) begin
               state_next = ST_READY;
            end
         end
         ST_READY: begin
            if (fault_present) begin
               state_next = ST_FAULT_REACTION;
            end else if (cmd.cmd_disable_voltage || cmd.cmd_quick_stop) begin
               state_next = ST_SO_DISABLED;
            end else if (cmd.cmd_switch_on) begin
               state_next = ST_SWITCHED_ON;
            end
         end
         ST_SWITCHED_ON: begin
            if (fault_present) begin
               state_next = ST_FAULT_REACTION;
            end else if (cmd.cmd_disable_voltage || cmd.cmd_quick_stop) begin
               state_next = ST_SO_DISABLED;
            end else if (cmd.cmd_shutdown) begin
               state_next = ST_READY;
            end else if (cmd.cmd_enable_op && cmd.enable_op_rise) begin
               state_next = ST_OP_ENABLED;
            end
         end
         ST_OP_ENABLED: begin
            if (fault_present) begin
               state_next = ST_FAULT_REACTION;
            end else if (cmd.cmd_disable_voltage) begin
               state_next = ST_SO_DISABLED;
            end else if (cmd.cmd_quick_stop) begin
               state_next = ST_QUICK_STOP;
            end else if (cmd.cmd_shutdown) begin
               state_next = ST_READY;
            end else if (cmd.cmd_disable_op) begin
               state_next = ST_SWITCHED_ON;
            end
         end
         ST_QUICK_STOP: begin
            if (fault_present) begin
               state_next = ST_FAULT_REACTION;
            end else if (cmd.cmd_disable_voltage || ramp_done) begin
               state_next = ST_SO_DISABLED;
            end else if (cmd.cmd_enable_op && cmd.enable_op_rise) begin
               state_next = ST_OP_ENABLED;
            end
         end
         ST_FAULT_REACTION: begin
            if (ramp_done) begin
               state_next = ST_FAULT;
            end
         end
         ST_FAULT: begin
            // Reset only counts here, and only once the fault has cleared
            if (cmd.cmd_fault_reset && !fault_present) begin
               state_next = ST_SO_DISABLED;
            end
         end
         default: begin
            state_next = ST_NOT_READY;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= ST_NOT_READY;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // Setpoint transfer
   // ****************************************
   // Pause freezes the held setpoint instead of zeroing it, so motion
   // resumes from the same task once the bit drops.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         setpoint_reg       <= '0;
         setpoint_valid_reg <= 1'b0;
      end else begin
         setpoint_valid_reg <= 1'b0;
         if (state_reg == ST_OP_ENABLED && cycle_strobe && !cmd.pause) begin
            setpoint_reg       <= setpoint_in;
            setpoint_valid_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         warning_reg <= '0;
      end else begin
         warning_reg <= warning_causes;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign power_stage_enable = (state_reg == ST_SWITCHED_ON) ||
                               (state_reg == ST_OP_ENABLED) ||
                               (state_reg == ST_QUICK_STOP) ||
                               (state_reg == ST_FAULT_REACTION);
   assign quick_stop_ramp    = (state_reg == ST_QUICK_STOP);
   assign emergency_ramp     = (state_reg == ST_FAULT_REACTION);
   assign halt_motion        = cmd.pause || (state_reg != ST_OP_ENABLED);
   assign setpoint_out       = setpoint_reg;
   assign setpoint_valid     = setpoint_valid_reg;
   assign warning_detail     = warning_reg;
   assign state              = state_reg;

endmodule : drive_power_state_machine
`default_nettype wire

// ### core/status_word_encoder.sv
// Status word encoder from state and drive conditions
`timescale 1ns/1ps
`default_nettype none
module status_word_encoder
   import drive_power_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire drive_state_t state,
   input  wire drive_cond_t  cond,
   output logic [15:0]       status_word
);

   logic [15:0] status_next;

   // ****************************************
   // Encoding
   // ****************************************
   always_comb begin
      status_next = WORD_ZERO;
      unique case (state)
         ST_NOT_READY: begin
         end
         ST_SO_DISABLED: begin
            status_next[SW_SO_DISABLED] = 1'b1;
         end
         ST_READY: begin
            status_next[SW_QUICK_STOP] = 1'b1;
            status_next[SW_READY]      = 1'b1;
         end
         ST_SWITCHED_ON: begin
            status_next[SW_QUICK_STOP]  = 1'b1;
            status_next[SW_SWITCHED_ON] = 1'b1;
            status_next[SW_READY]       = 1'b1;
         end
         ST_OP_ENABLED: begin
            status_next[SW_QUICK_STOP]  = 1'b1;
            status_next[SW_OP_ENABLED]  = 1'b1;
            status_next[SW_SWITCHED_ON] = 1'b1;
            status_next[SW_READY]       = 1'b1;
         end
         ST_QUICK_STOP: begin
            status_next[SW_OP_ENABLED]  = 1'b1;
            status_next[SW_SWITCHED_ON] = 1'b1;
            status_next[SW_READY]       = 1'b1;
         end
         ST_FAULT_REACTION: begin
            status_next[SW_FAULT]       = 1'b1;
            status_next[SW_OP_ENABLED]  = 1'b1;
            status_next[SW_SWITCHED_ON] = 1'b1;
            status_next[SW_READY]       = 1'b1;
         end
         ST_FAULT: begin
            status_next[SW_FAULT] = 1'b1;
         end
         default: begin
            status_next = WORD_ZERO;
         end
      endcase
      status_next[SW_VOLTAGE] = cond.voltage_present;
      status_next[SW_WARNING] = cond.warning_any;
      status_next[SW_REMOTE]  = 1'b1;
      status_next[SW_TARGET]  = cond.target_reached;
      status_next[SW_LIMIT]   = cond.limit_active;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_word <= WORD_ZERO;
      end else begin
         status_word <= status_next;
      end
   end

endmodule : status_word_encoder
`default_nettype wire

// ### tb/drive_power_state_machine_assertions.sv
// Port checker for the drive power state machine
`timescale 1ns/1ps
`default_nettype none
module drive_power_state_machine_assertions
   import drive_power_pkg::*;
#(
   parameter int WARN_W = 8
)
(
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic [15:0]       control_word,
   input wire logic              cycle_strobe,
   input wire logic [7:0]        mode_of_operation,
   input wire logic              booting,
   input wire logic              fault_present,
   input wire logic              voltage_present,
   input wire logic [WARN_W-1:0] warning_causes,
   input wire logic              target_reached,
   input wire logic              limit_active,
   input wire logic [31:0]       setpoint_in,
   input wire logic [15:0]       status_word,
   input wire logic [31:0]       setpoint_out,
   input wire logic              setpoint_valid,
   input wire logic              power_stage_enable,
   input wire logic              quick_stop_ramp,
   input wire logic              emergency_ramp,
   input wire logic              halt_motion,
   input wire mode_bits_t        mode_bits,
   input wire drive_state_t      state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Expected bits 6,5,3,2,1,0 of the status word per state
   function automatic logic [5:0] code_of(input drive_state_t s);
      case (s)
         ST_SO_DISABLED:    return 6'h20;
         ST_READY:          return 6'h11;
         ST_SWITCHED_ON:    return 6'h13;
         ST_OP_ENABLED:     return 6'h17;
         ST_QUICK_STOP:     return 6'h07;
         ST_FAULT:          return 6'h08;
         ST_FAULT_REACTION: return 6'h0F;
         default:           return 6'h00;
      endcase
   endfunction : code_of

   state_code_a: assert property (!$past(sys_rst) |-> (({status_word[6:5], status_word[3:0]}
      ^ code_of($past(state))) & ($past(state) == ST_FAULT_REACTION ? 6'h2F : 6'h3F)) == 6'h00)
      else $error("status word state code wrong");
   remote_bit_a: assert property (!$past(sys_rst) |-> status_word[9])
      else $error("remote bit low");
   voltage_bit_a: assert property (!$past(sys_rst) |-> status_word[4] == $past(voltage_present))
      else $error("voltage bit wrong");
   warning_bit_a: assert property (!$past(sys_rst) |-> status_word[7] == (|$past(warning_causes)))
      else $error("warning bit wrong");
   flag_bits_a: assert property (!$past(sys_rst)
      |-> status_word[11:10] == $past({limit_active, target_reached}))
      else $error("target or limit bit wrong");
   not_ready_a: assert property (state == ST_NOT_READY && (booting || fault_present) |=> state == ST_NOT_READY)
      else $error("left not ready too early");
   refuse_enable_a: assert property (state == ST_SO_DISABLED && !voltage_present
      |=> state inside {ST_SO_DISABLED, ST_FAULT_REACTION}) else $error("enabled without voltage");
   enable_edge_a: assert property (state == ST_SWITCHED_ON && !fault_present && $rose(control_word[3])
      && control_word[2:0] == 3'h7 |=> state == ST_OP_ENABLED) else $error("enable edge ignored");
   setpoint_take_a: assert property (cycle_strobe && state == ST_OP_ENABLED && !control_word[8]
      |=> setpoint_valid && setpoint_out == $past(setpoint_in)) else $error("setpoint not taken");
   setpoint_gate_a: assert property (setpoint_valid
      |-> $past(cycle_strobe && state == ST_OP_ENABLED && !control_word[8])) else $error("setpoint taken wrongly");
   halt_pause_a: assert property (control_word[8] |-> halt_motion)
      else $error("pause without halt");
   quick_ramp_a: assert property (state == ST_QUICK_STOP |-> quick_stop_ramp && !emergency_ramp)
      else $error("quick stop ramp missing");
   fault_react_a: assert property (fault_present && state inside {ST_SO_DISABLED, ST_READY, ST_SWITCHED_ON,
      ST_OP_ENABLED, ST_QUICK_STOP} |=> state == ST_FAULT_REACTION && emergency_ramp) else $error("no fault reaction");
   fault_off_a: assert property (state == ST_FAULT |-> !power_stage_enable && halt_motion)
      else $error("stage on in fault");
   mode_bits_a: assert property (mode_of_operation == MODE_PROFILE_POSITION
      |-> mode_bits.new_setpoint == control_word[4] && mode_bits.absolute_relative == control_word[6])
      else $error("mode bits wrong");
endmodule : drive_power_state_machine_assertions

bind drive_power_state_machine drive_power_state_machine_assertions #(.WARN_W(WARN_W)) i_checker (
   .clk(clk), .sys_rst(sys_rst), .control_word(control_word), .cycle_strobe(cycle_strobe),
   .mode_of_operation(mode_of_operation), .booting(booting), .fault_present(fault_present),
   .voltage_present(voltage_present), .warning_causes(warning_causes), .target_reached(target_reached),
   .limit_active(limit_active), .setpoint_in(setpoint_in), .status_word(status_word),
   .setpoint_out(setpoint_out), .setpoint_valid(setpoint_valid), .power_stage_enable(power_stage_enable),
   .quick_stop_ramp(quick_stop_ramp), .emergency_ramp(emergency_ramp), .halt_motion(halt_motion),
   .mode_bits(mode_bits), .state(state)
);
`default_nettype wire

// ### tb/drive_power_state_machine_bench.sv
// Self-checking bench for the drive power state machine
`timescale 1ns/1ps
`default_nettype none
module drive_power_state_machine_bench
   import drive_power_pkg::*;
;
   logic         clk = 1'h0, sys_rst = 1'h1, booting = 1'h1, fault_present = 1'h0, voltage_present = 1'h0;
   logic         target_reached = 1'h0, limit_active = 1'h0, ramp_done = 1'h0;
   logic [15:0]  cw_cmd = 16'h0000;
   logic [31:0]  sp_cmd = 32'h00000000;
   logic [7:0]   mode_of_operation = 8'h01, warning_causes = 8'h00, warning_detail;
   logic [15:0]  control_word, status_word;
   logic [31:0]  setpoint_in, setpoint_out;
   logic         cycle_strobe, setpoint_valid, power_stage_enable, quick_stop_ramp, emergency_ramp, halt_motion;
   mode_bits_t   mode_bits;
   drive_state_t state;
   int           error_cnt = 0, checks = 0, sp_cnt = 0;

   always #10 clk = ~clk;
   always @(posedge clk) if (setpoint_valid === 1'h1) sp_cnt <= sp_cnt + 1;

   fieldbus_master_model #(.PERIOD(4)) i_master (.clk(clk), .sys_rst(sys_rst), .cw_cmd(cw_cmd),
      .sp_cmd(sp_cmd), .control_word(control_word), .cycle_strobe(cycle_strobe), .setpoint_in(setpoint_in));

   drive_power_state_machine #(.WARN_W(8)) i_dut (.clk(clk), .sys_rst(sys_rst), .control_word(control_word),
      .cycle_strobe(cycle_strobe), .mode_of_operation(mode_of_operation), .booting(booting),
      .fault_present(fault_present), .voltage_present(voltage_present), .warning_causes(warning_causes),
      .target_reached(target_reached), .limit_active(limit_active), .ramp_done(ramp_done),
      .setpoint_in(setpoint_in), .status_word(status_word), .warning_detail(warning_detail),
      .setpoint_out(setpoint_out), .setpoint_valid(setpoint_valid), .power_stage_enable(power_stage_enable),
      .quick_stop_ramp(quick_stop_ramp), .emergency_ramp(emergency_ramp), .halt_motion(halt_motion),
      .mode_bits(mode_bits), .state(state));

   // ******************
   // Helpers
   // ******************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask : tick

   task automatic end_sim;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   // Status lags the state by one edge, hence the two extra cycles
   task automatic go(input logic [15:0] cw, input drive_state_t s);
      int n;
      cw_cmd = cw;
      n = 0;
      while (state !== s && n < 40) begin
         tick(1);
         n++;
      end
      check("state", 32'(state), 32'(s));
      // A late arrival on the last try is still a timeout only if the state is wrong
      if (state !== s) end_sim();
      else tick(2);
   endtask : go

   task automatic stay(input logic [15:0] cw, input drive_state_t s);
      cw_cmd = cw;
      tick(16);
      check("state held", 32'(state), 32'(s));
   endtask : stay

   // ******************
   // Scenarios
   // ******************
   task automatic t_power_up;
      stay(16'h0006, ST_NOT_READY);
      check("status", 32'(status_word), 32'h00000200);
      booting = 1'h0;
      fault_present = 1'h1;
      stay(16'h0006, ST_NOT_READY);
      fault_present = 1'h0;
      go(16'h0006, ST_SO_DISABLED);
      check("status", 32'(status_word), 32'h00000240);
      stay(16'h000F, ST_SO_DISABLED);
      voltage_present = 1'h1;
      go(16'h0006, ST_READY);
      check("status", 32'(status_word), 32'h00000231);
   endtask : t_power_up

   task automatic t_flags;
      warning_causes = 8'h10;
      target_reached = 1'h1;
      limit_active = 1'h1;
      tick(2);
      check("flags", 32'(status_word & 16'h0C80), 32'h00000C80);
      check("warn detail", 32'(warning_detail), 32'h00000010);
      warning_causes = 8'h00;
      target_reached = 1'h0;
      limit_active = 1'h0;
      tick(2);
      check("flags", 32'(status_word & 16'h0C80), 32'h00000000);
   endtask : t_flags

   task automatic t_operate;
      logic [7:0] m [5] = '{MODE_PROFILE_POSITION, MODE_PROFILE_VELOCITY, MODE_PROFILE_TORQUE,
                            MODE_REFERENCE_SEARCH, MODE_INTERPOLATED};
      int sp_base;
      go(16'h0007, ST_SWITCHED_ON);
      check("stage", 32'(power_stage_enable), 32'h00000001);
      sp_base = sp_cnt;
      stay(16'h0007, ST_SWITCHED_ON);
      check("idle setpoints", 32'(sp_cnt - sp_base), 32'h00000000);
      go(16'h000F, ST_OP_ENABLED);
      check("status", 32'(status_word), 32'h00000237);
      sp_cmd = 32'hC0DE1234;
      sp_base = sp_cnt;
      stay(16'h000F, ST_OP_ENABLED);
      check("setpoint count", 32'(sp_cnt - sp_base), 32'h00000004);
      check("setpoint", setpoint_out, 32'hC0DE1234);
      stay(16'h010F, ST_OP_ENABLED);
      sp_cmd = 32'h00000055;
      sp_base = sp_cnt;
      tick(12);
      check("paused count", 32'(sp_cnt - sp_base), 32'h00000000);
      check("halt", 32'(halt_motion), 32'h00000001);
      check("kept setpoint", setpoint_out, 32'hC0DE1234);
      stay(16'hFE0F, ST_OP_ENABLED);
      check("halt", 32'(halt_motion), 32'h00000000);
      cw_cmd = 16'h007F;
      tick(6);
      foreach (m[i]) begin
         mode_of_operation = m[i];
         tick(1);
         check("new setpoint", 32'(mode_bits.new_setpoint), 32'(m[i] == MODE_PROFILE_POSITION));
         check("immediate", 32'(mode_bits.change_immediately), 32'(m[i] == MODE_PROFILE_POSITION));
         check("search", 32'(mode_bits.reference_search_start), 32'(m[i] == MODE_REFERENCE_SEARCH));
      end
      mode_of_operation = MODE_PROFILE_POSITION;
   endtask : t_operate

   task automatic t_quick_stop;
      go(16'h0007, ST_SWITCHED_ON);
      go(16'h000F, ST_OP_ENABLED);
      go(16'h000B, ST_QUICK_STOP);
      check("quick ramp", 32'(quick_stop_ramp), 32'h00000001);
      check("status", 32'(status_word), 32'h00000217);
      ramp_done = 1'h1;
      go(16'h000B, ST_SO_DISABLED);
      ramp_done = 1'h0;
      go(16'h0006, ST_READY);
      go(16'h0000, ST_SO_DISABLED);
   endtask : t_quick_stop

   task automatic t_fault;
      go(16'h0006, ST_READY);
      go(16'h0007, ST_SWITCHED_ON);
      go(16'h000F, ST_OP_ENABLED);
      stay(16'h008F, ST_OP_ENABLED);
      fault_present = 1'h1;
      go(16'h000F, ST_FAULT_REACTION);
      check("emergency ramp", 32'(emergency_ramp), 32'h00000001);
      check("status", 32'(status_word & 16'h004F), 32'h0000000F);
      ramp_done = 1'h1;
      go(16'h000F, ST_FAULT);
      ramp_done = 1'h0;
      check("stage", 32'(power_stage_enable), 32'h00000000);
      check("status", 32'(status_word & 16'h004F), 32'h00000008);
      stay(16'h0080, ST_FAULT);
      fault_present = 1'h0;
      stay(16'h0080, ST_FAULT);
      stay(16'h0000, ST_FAULT);
      go(16'h0080, ST_SO_DISABLED);
   endtask : t_fault

   initial begin
      tick(12);
      sys_rst = 1'h0;
      t_power_up();
      t_flags();
      t_operate();
      t_quick_stop();
      t_fault();
      end_sim();
   end
endmodule : drive_power_state_machine_bench
`default_nettype wire

// ### tb/fieldbus_master_model.sv
// Fieldbus master model: hands over control word and setpoint once a cycle
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model #(
   parameter int PERIOD = 4
)
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] cw_cmd,
   input  wire logic [31:0] sp_cmd,
   output logic [15:0]      control_word,
   output logic             cycle_strobe,
   output logic [31:0]      setpoint_in
);
   int cnt;
   // New words only at a cycle boundary, so edge detectors see real bus timing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt          <= 0;
         cycle_strobe <= 1'h0;
         control_word <= 16'h0000;
         setpoint_in  <= 32'h00000000;
      end else begin
         cnt          <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         cycle_strobe <= (cnt == PERIOD - 1);
         if (cnt == PERIOD - 1) begin
            control_word <= cw_cmd;
            setpoint_in  <= sp_cmd;
         end
      end
   end
endmodule : fieldbus_master_model
`default_nettype wire
